// >>> logic/src_pkg.sv
package src_pkg;
   // Register map over the Wishbone bus. The offsets are word indices, so
   // the byte address is four times the index.
   localparam logic [7:0] SRC_IDX_STOP_CFG = 8'h08;
   localparam logic [7:0] SRC_IDX_WDOG_CFG = 8'h0F;
   localparam logic [7:0] SRC_IDX_STATUS = 8'h10;
   localparam logic [7:0] SRC_IDX_DELAY = 8'h11;
   localparam int SRC_AW = 8;
   // Field positions in the stop recovery configuration register.
   localparam int SRC_BIT_DIV16 = 0;
   localparam int SRC_BIT_XDIV = 1;
   localparam int SRC_LSB_SRCSEL = 2;
   localparam int SRC_MSB_SRCSEL = 4;
   localparam int SRC_BIT_DELAY = 5;
   localparam int SRC_BIT_LEVEL = 6;
   localparam int SRC_BIT_FLAG = 7;
   // Field positions in the watchdog mode configuration register.
   localparam int SRC_LSB_TAP = 0;
   localparam int SRC_MSB_TAP = 1;
   localparam int SRC_BIT_WSEL = 4;
   // Reset values.
   localparam logic [7:0] SRC_RST_STOP_CFG = 8'h20;
   localparam logic [7:0] SRC_RST_WDOG_CFG = 8'h00;
   // Start-up delay length in crystal clock cycles.
   localparam int SRC_START_DLY = 16;
   localparam int SRC_DIV_STAGES = 5;

   typedef enum logic [2:0]
   {
      SRC_RUN = 3'b001,
      SRC_STOP = 3'b010,
      SRC_WAIT = 3'b100
   } src_state_t;
endpackage

// >>> logic/src_clk_if.sv
`timescale 1ns/1ps
// Carries the clock-division settings from the register file to the divider.
interface src_clk_if;
   logic div16;
   logic crystal_clock_input_full;
   logic sys_tick;
   logic tmr_tick;
   modport ctrl (output div16, output crystal_clock_input_full, input sys_tick, input tmr_tick);
   modport div (input div16, input crystal_clock_input_full, output sys_tick, output tmr_tick);
endinterface

// >>> logic/src_divider.sv
`timescale 1ns/1ps
module src_divider
   import src_pkg::*;
(
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst,
   // Settings and ticks.
   src_clk_if.div cif
);
   typedef struct packed
   {
      logic [SRC_DIV_STAGES-1:0] cnt;
      logic tick;
   } src_div_t;

   src_div_t s_q, s_d;

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      logic [SRC_DIV_STAGES-1:0] lim;
      lim = 5'h00;
      s_d = s_q;
      // Undivided crystal or crystal over two, then optionally over sixteen.
      lim = cif.crystal_clock_input_full ? 5'h00 : 5'h01;
      if (cif.div16)
      begin
         lim = cif.crystal_clock_input_full ? 5'h0F : 5'h1F;
      end
      if (s_q.cnt >= lim)
      begin
         s_d.cnt = 5'h00;
         s_d.tick = 1'b1;
      end
      else
      begin
         s_d.cnt = s_q.cnt + 5'h01;
         s_d.tick = 1'b0;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // System and timer clocks share one divider, so they tick together.
   assign cif.sys_tick = s_q.tick;
   assign cif.tmr_tick = s_q.tick;
endmodule // src_divider

// >>> logic/src_wdog_sel.sv
`timescale 1ns/1ps
module src_wdog_sel
   import src_pkg::*;
(
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst,
   // Source choice and candidate ticks.
   input wire logic use_crystal_clock_input,
   input wire logic rc_tick,
   // Selected tick, registered.
   output logic wdog_tick
);
   typedef struct packed
   {
      logic tick;
   } src_ws_t;

   src_ws_t s_q, s_d;

   always_comb
   begin
      s_d.tick = use_crystal_clock_input ? 1'b1 : rc_tick;
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign wdog_tick = s_q.tick;
endmodule // src_wdog_sel

// >>> logic/src_stop_recovery.sv
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps
// Function
// - Divide-by-sixteen field set divides system and timer clocks by 16.
// - Divide field 0 gives crystal over two; 1 gives undivided crystal.
// - Stop recovery register is write-only except bit 7, read-only.
// - Watchdog clock from RC oscillator when select 0, crystal when 1.
// - Watchdog mode register is write-only; reads never return it.
// - Bit 5 set inserts a start-up delay after reset and stop recovery.
module src_stop_recovery
   import src_pkg::*;
#(
   parameter int START_DLY = SRC_START_DLY
)
(
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst,
   // Wishbone slave.
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Stop mode entry request and wake-up event from the core.
   input wire logic stop_req,
   input wire logic wake_evt,
   // Watchdog RC oscillator tick.
   input wire logic rc_tick,
   // Clock ticks and status.
   output logic sys_tick,
   output logic timer_clock,
   output logic watchdog_tick,
   output logic core_run,
   output logic [1:0] watchdog_timeout_tap
);
   // The delay counter is sixteen bits wide and must count at least once.
   if (START_DLY < 1 || START_DLY > 65535)
   begin : g_bad_dly
      $error("START_DLY out of range");
   end

   typedef struct packed
   {
      logic [7:0] stop_cfg;
      logic [7:0] wdog_cfg;
      logic flag;
      logic [15:0] dly;
      src_state_t st;
      logic ack;
      logic [31:0] rdat;
   } src_regs_t;

   src_regs_t r_q, r_d;
   src_clk_if cif();

   function automatic logic hit(input logic [31:0] adr, input logic [7:0] idx);
      hit = (adr[31:2] == {22'h000000, idx}) && (adr[1:0] == 2'h0);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      logic req;
      logic wr;
      req = wb_cyc_i && wb_stb_i && !r_q.ack;
      wr = req && wb_we_i && wb_sel_i[0];
      r_d = r_q;
      r_d.ack = req;
      r_d.rdat = 32'h00000000;
      if (wr && hit(wb_adr_i, SRC_IDX_STOP_CFG))
      begin
         // Bit 7 ignores writes and keeps the hardware flag.
         r_d.stop_cfg = {1'b0, wb_dat_i[6:0]};
      end
      if (wr && hit(wb_adr_i, SRC_IDX_WDOG_CFG))
      begin
         r_d.wdog_cfg = wb_dat_i[7:0];
      end
      if (req && !wb_we_i)
      begin
         // Write-only fields read as zero; the flag bit, the state and the delay count show.
         if (hit(wb_adr_i, SRC_IDX_STOP_CFG))
         begin
            r_d.rdat = {24'h000000, r_q.flag, 7'h00};
         end
         else if (hit(wb_adr_i, SRC_IDX_WDOG_CFG))
         begin
            r_d.rdat = 32'h00000000;
         end
         else if (hit(wb_adr_i, SRC_IDX_STATUS))
         begin
            r_d.rdat = {29'h00000000, r_q.st};
         end
         else if (hit(wb_adr_i, SRC_IDX_DELAY))
         begin
            r_d.rdat = {16'h0000, r_q.dly};
         end
      end
      case (r_q.st)
         SRC_RUN:
         begin
            if (stop_req)
            begin
               r_d.st = SRC_STOP;
            end
         end
         SRC_STOP:
         begin
            if (wake_evt)
            begin
               r_d.flag = 1'b1;
               r_d.dly = 16'(START_DLY);
               r_d.st = r_q.stop_cfg[SRC_BIT_DELAY] ? SRC_WAIT : SRC_RUN;
            end
         end
         SRC_WAIT:
         begin
            if (r_q.dly <= 16'h0001)
            begin
               r_d.dly = 16'h0000;
               r_d.st = SRC_RUN;
            end
            else
            begin
               r_d.dly = r_q.dly - 16'h0001;
            end
         end
         default:
         begin
            r_d.st = SRC_RUN;
         end
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         // Reset is the power-on case: delay on by default, flag cleared.
         r_q.stop_cfg <= SRC_RST_STOP_CFG;
         r_q.wdog_cfg <= SRC_RST_WDOG_CFG;
         r_q.flag <= 1'b0;
         r_q.dly <= 16'(START_DLY);
         r_q.st <= SRC_WAIT;
         r_q.ack <= 1'b0;
         r_q.rdat <= 32'h00000000;
      end
      else
      begin
         r_q <= r_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign cif.div16 = r_q.stop_cfg[SRC_BIT_DIV16];
   assign cif.crystal_clock_input_full = r_q.stop_cfg[SRC_BIT_XDIV];

   src_divider u_div
   (
      .mclk(mclk),
      .rst(rst),
      .cif(cif.div)
   );

   src_wdog_sel u_wsel
   (
      .mclk(mclk),
      .rst(rst),
      .use_crystal_clock_input(r_q.wdog_cfg[SRC_BIT_WSEL]),
      .rc_tick(rc_tick),
      .wdog_tick(watchdog_tick)
   );

   // System and timer clocks are stopped while the core sleeps in stop mode.
   assign sys_tick = cif.sys_tick && (r_q.st != SRC_STOP);
   assign timer_clock = cif.tmr_tick && (r_q.st != SRC_STOP);
   assign core_run = (r_q.st == SRC_RUN);
   assign watchdog_timeout_tap = r_q.wdog_cfg[SRC_MSB_TAP:SRC_LSB_TAP];
   assign wb_ack_o = r_q.ack;
   assign wb_dat_o = r_q.rdat;
endmodule // src_stop_recovery

// >>> dv/src_monitor.sv
`timescale 1ns/1ps
module src_monitor
(
   // Watched ports.
   input wire logic mclk,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic sys_tick,
   input wire logic timer_clock,
   input wire logic core_run,
   input wire logic stop_req
);
   logic rd;
   assign rd = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   //////////////////////////////
   // Read data is judged one cycle after the request is taken, while it stands.
   property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
   property p_one; wb_ack_o |=> !wb_ack_o; endproperty
   property p_idle; !wb_cyc_i |=> !wb_ack_o; endproperty
   property p_wdog; rd && wb_adr_i == 32'h3C |=> wb_dat_o == 32'h0; endproperty
   property p_stop; rd && wb_adr_i == 32'h20 |=> {wb_dat_o[31:8], wb_dat_o[6:0]} == 31'h0;
   endproperty
   property p_pair; sys_tick == timer_clock; endproperty
   // Ticks keep running during the start-up delay, so only stop entry is judged here.
   property p_gate; core_run && stop_req |=> !sys_tick && !timer_clock && !core_run;
   endproperty
   property p_dly; $fell(rst) |-> !core_run ##1 !core_run ##[1:8] core_run; endproperty
   a_ack: assert property (p_ack) else $error("no ack");
   a_one: assert property (p_one) else $error("long ack");
   a_idle: assert property (p_idle) else $error("stray ack");
   a_wdog: assert property (p_wdog) else $error("wdog read");
   a_stop: assert property (p_stop) else $error("stop read");
   a_pair: assert property (p_pair) else $error("tick pair");
   a_gate: assert property (p_gate) else $error("tick gate");
   a_dly: assert property (p_dly) else $error("delay");
   c_rd: cover property (rd);
   c_run: cover property (!core_run ##1 core_run);
   c_tick: cover property (sys_tick ##1 sys_tick);
endmodule // src_monitor
bind src_stop_recovery src_monitor u_mon (.mclk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
   .wb_adr_i, .wb_dat_o, .wb_ack_o, .sys_tick, .timer_clock, .core_run, .stop_req);

// >>> dv/src_stop_recovery_tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin num_errors++; \
   $display("[FAIL] %0t %h %h", $time, a, e); end end
module src_stop_recovery_tb;
   logic mclk = 0, rst = 1, wb_cyc_i = 0, wb_we_i = 0, stop_req = 0, wake_evt = 0;
   logic rc_tick = 0, prev, wb_ack_o, sys_tick, timer_clock, watchdog_tick, core_run;
   logic [31:0] wb_adr_i = 0, wb_dat_i = 0, wb_dat_o, got, r;
   logic [1:0] tap;
   localparam int DLY = 2;
   int num_errors = 0, check_count = 0, seed = 71292;
   // Four-state counts, so that an unknown tick cannot slip through a compare.
   integer n, m;
   src_stop_recovery #(.START_DLY(DLY)) dut (.mclk, .rst, .wb_cyc_i, .wb_stb_i(wb_cyc_i),
      .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i(4'hF), .wb_dat_o, .wb_ack_o, .stop_req,
      .wake_evt, .rc_tick, .sys_tick, .timer_clock, .watchdog_tick, .core_run,
      .watchdog_timeout_tap(tap));
   initial forever #25 mclk = ~mclk;
   //////////////////////////////
   task automatic give_verdict();
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic hang(int k);
      if (k >= 99)
      begin
         num_errors++;
         give_verdict();
      end
   endtask
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      int k;
      @(posedge mclk);
      wb_cyc_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      for (k = 0; k < 99 && wb_ack_o !== 1'b1; k++) @(posedge mclk);
      hang(k);
      got = wb_dat_o;
      wb_cyc_i <= 1'b0;
   endtask
   task automatic reset_dut();
      rst <= 1'b1;
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
   endtask
   task automatic nap(output int c);
      @(posedge mclk);
      stop_req <= 1'b1;
      @(posedge mclk);
      stop_req <= 1'b0;
      repeat (8) @(posedge mclk);
      wake_evt <= 1'b1;
      @(posedge mclk);
      wake_evt <= 1'b0;
      for (c = 0; c < 99 && core_run !== 1'b1; c++) @(posedge mclk);
      hang(c);
   endtask
   // A window of 64 cycles holds whole periods of every rate, so phase cannot matter.
   function automatic int exp_ticks(int i);
      return 64 / ((i[1] ? 1 : 2) * (i[0] ? 16 : 1));
   endfunction
   //////////////////////////////
   initial
   begin
      reset_dut();
      // The first read after reset still finds the start-up wait state.
      bus(1'b0, 32'h40, 32'h0);
      `CHK(got, 32'h4)
      bus(1'b0, 32'h20, 32'h0);
      `CHK(got, 32'h0)
      for (int i = 0; i < 4; i++)
      begin
         r = $random(seed);
         bus(1'b1, 32'h20, {r[31:8], 8'hE4 | 8'(i)});
         bus(1'b0, 32'h20, r);
         `CHK(got, 32'h0)
         repeat (40) @(posedge mclk);
         n = 0;
         m = 0;
         repeat (64)
         begin
            @(posedge mclk);
            n += sys_tick;
            m += timer_clock;
         end
         `CHK(n, exp_ticks(i))
         `CHK(m, exp_ticks(i))
      end
      for (int i = 0; i < 2; i++)
      begin
         r = $random(seed);
         bus(1'b1, 32'h3C, {r[31:5], i[0], r[3:0]});
         bus(1'b0, 32'h3C, r);
         `CHK(got, 32'h0)
         `CHK(tap, r[1:0])
         repeat (32)
         begin
            @(posedge mclk);
            prev = rc_tick;
            rc_tick <= 1'($random(seed));
            #1;
            `CHK(watchdog_tick, i[0] | prev)
         end
      end
      bus(1'b1, 32'h20, 32'h64);
      nap(n);
      bus(1'b0, 32'h20, 32'h0);
      `CHK(got, 32'h80)
      bus(1'b1, 32'h20, 32'h44);
      nap(m);
      `CHK(n > m, 1'b1)
      bus(1'b1, 32'h60, r);
      bus(1'b0, 32'h60, r);
      `CHK(got, 32'h0)
      reset_dut();
      // One count of the delay has passed when the first read is taken.
      bus(1'b0, 32'h44, 32'h0);
      `CHK(got, 32'(DLY - 1))
      bus(1'b0, 32'h20, 32'h0);
      `CHK(got, 32'h0)
      give_verdict();
   end
endmodule // src_stop_recovery_tb
